//--- pkg/mmc_pkg.sv
package mmc_pkg;
  localparam logic [31:0] MMC_KSEG_START = 32'h8000_0000;
  localparam logic [2:0] MMC_TOP_CACHED = 3'h4;
  localparam logic [2:0] MMC_TOP_UNCACHED = 3'h5;
  localparam logic [31:0] MMC_KPHYS_MASK = 32'h1FFF_FFFF;
  localparam logic [31:0] MMC_RST_ADDR = 32'h0000_0000;
  localparam logic [23:0] MMC_RST_POLICY = 24'h00_0000;
  localparam int MMC_WAYS = 2;
  localparam int MMC_SETS = 128;
  localparam int MMC_IDX_W = 7;
  localparam int MMC_TAG_W = 20;
  localparam int MMC_LINE_BEATS = 4;
  localparam int MMC_BEAT_W = 2;
  localparam int MMC_IDX_LSB = 5;
  localparam int MMC_TAG_LSB = 12;
  localparam int MMC_BEAT_LSB = 3;
  localparam int MMC_REGIONS = 8;
  localparam int MMC_POL_W = 3;
  localparam logic [2:0] MMC_POL_WB = 3'h0;
  localparam logic [2:0] MMC_POL_UNC = 3'h1;
  localparam logic [2:0] MMC_POL_WTA = 3'h2;
  localparam logic [2:0] MMC_POL_WTN = 3'h3;
  localparam logic [31:0] MMC_VEC_GENERAL = 32'h8000_0180;
  localparam logic [31:0] MMC_VEC_INTR = 32'h8000_0200;
  typedef enum logic [1:0] {MMC_REQ_FETCH, MMC_REQ_LOAD, MMC_REQ_STORE}
    mmc_req_e;
  typedef enum logic [2:0] {
    MMC_EXC_NONE, MMC_EXC_ADDR, MMC_EXC_BOUND, MMC_EXC_WATCH, MMC_EXC_INTR
  } mmc_exc_e;
  typedef enum logic [2:0] {
    MMC_ST_IDLE, MMC_ST_LOOK, MMC_ST_FILL, MMC_ST_UNC, MMC_ST_WMEM
  } mmc_state_e;
endpackage : mmc_pkg

//--- hw/mmc_xlate.sv
`timescale 1ns/1ps
module mmc_xlate (
  input wire logic [31:0] vaddr,
  input wire logic user_mode,
  input wire logic is_fetch,
  input wire logic [31:0] ibase,
  input wire logic [31:0] ibound,
  input wire logic [31:0] dbase,
  input wire logic [31:0] dbound,
  input wire logic [23:0] region_cache_policy,
  output logic [31:0] paddr,
  output logic uncached,
  output logic [2:0] policy,
  output logic addr_err,
  output logic bound_err
);
  import mmc_pkg::*;
  logic [31:0] base;
  logic [31:0] bound;
  logic [2:0] region;
  always_comb begin
    base = is_fetch ? ibase : dbase;
    bound = is_fetch ? ibound : dbound;
    region = vaddr[31:29];
    policy = region_cache_policy[region*MMC_POL_W +: MMC_POL_W];
    addr_err = user_mode && (vaddr >= MMC_KSEG_START);
    bound_err = 1'b0;
    if (vaddr < MMC_KSEG_START) begin
      bound_err = user_mode && (vaddr > bound);
      paddr = user_mode ? vaddr + base : vaddr;
    end else if (region[2:1] == 2'b10) begin
      paddr = vaddr & MMC_KPHYS_MASK;
    end else begin
      paddr = vaddr;
    end
    uncached = (region == MMC_TOP_UNCACHED) || (policy == MMC_POL_UNC);
    if (region == MMC_TOP_CACHED && policy == MMC_POL_UNC) begin
      uncached = 1'b0;
    end
  end
endmodule : mmc_xlate

//--- hw/mmc_way_sel.sv
`timescale 1ns/1ps
module mmc_way_sel (
  input wire logic lock_a,
  input wire logic lru_a,
  output logic victim_b
);
  import mmc_pkg::*;
  always_comb begin
    victim_b = lock_a ? 1'b1 : ~lru_a;
  end
endmodule : mmc_way_sel

//--- hw/mmc_top.sv
`timescale 1ns/1ps
// How it works
// - User access: bound check, add base
// - Out of bound raises bound exception
// - Kernel addresses use fixed mapping
// - Low 2 GB is mapped user segment
// - Kernel cached window at 0x80000000
// - Kernel uncached window at 0xA0000000
// - Top gigabyte unmapped kernel space
// - Kernel segments kernel-mode only
// - Kernel mode on reset and exceptions
// - Watch address match raises exception
// - Optional dedicated interrupt vector
// - 8KB two-way, 32B lines, VIPT
// - Icache tag: 20 bits, valid, parity
// - Icache 64 bits, refill per cycle
// - Lock set A: refill set B only
// - Icache waits line, dcache first word
// - Dcache byte parity, tag parity bit
// - Write-back hit dirties, miss fills first
// - Uncached bypasses cache, stores to memory
// - Write-through allocate: hit writes both
// - No-allocate miss writes memory only
// - Policy chosen per range by software
// - Eight 512MB region policies
module mmc_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire mmc_pkg::mmc_req_e req_kind,
  input wire logic [31:0] req_vaddr,
  input wire logic [63:0] req_wdata,
  input wire logic [7:0] req_be,
  input wire logic intr_req,
  input wire logic exc_return,
  input wire logic [31:0] ibase,
  input wire logic [31:0] ibound,
  input wire logic [31:0] dbase,
  input wire logic [31:0] dbound,
  input wire logic [31:0] iwatch,
  input wire logic [31:0] dwatch,
  input wire logic watch_en,
  input wire logic intr_vec_en,
  input wire logic icache_lock_a,
  input wire logic dcache_lock_a,
  input wire logic [23:0] region_cache_policy,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic mem_block,
  output logic [31:0] mem_addr,
  output logic [63:0] mem_wdata,
  output logic [7:0] mem_be,
  output logic resp_valid,
  output logic [63:0] resp_rdata,
  output logic busy,
  output logic exc_valid,
  output mmc_pkg::mmc_exc_e exc_code,
  output logic [31:0] exc_vector,
  output logic [31:0] bad_vaddr,
  output logic kernel_mode,
  output logic parity_err
);
  import mmc_pkg::*;
  typedef struct packed {
    mmc_state_e st;
    logic kmode;
    mmc_req_e kind;
    logic [31:0] va;
    logic [31:0] pa;
    logic [2:0] pol;
    logic unc;
    logic [63:0] wd;
    logic [7:0] be;
    logic [MMC_BEAT_W-1:0] beat;
    logic way;
    logic early;
    logic sb_v;
    logic sb_way;
    logic [MMC_IDX_W-1:0] sb_idx;
    logic [MMC_BEAT_W-1:0] sb_beat;
    logic [63:0] sb_d;
    logic [7:0] sb_be;
    logic sb_dirty;
    logic mreq;
    logic mwe;
    logic mblk;
    logic [31:0] maddr;
    logic [63:0] mwd;
    logic [7:0] mbe;
    logic rv;
    logic [63:0] rd;
    logic ev;
    mmc_exc_e ec;
    logic [31:0] evec;
    logic [31:0] bva;
    logic perr;
  } mmc_state_s;
  // Tag word: parity, valid, dirty, 20-bit tag; data: 64 bits + 8 parity
  typedef logic [MMC_TAG_W+2:0] mmc_tag_t;
  mmc_state_s r_ff, nxt_r;
  mmc_tag_t itag_ff [MMC_WAYS][MMC_SETS];
  mmc_tag_t dtag_ff [MMC_WAYS][MMC_SETS];
  logic [71:0] idat_ff [MMC_WAYS][MMC_SETS*MMC_LINE_BEATS];
  logic [71:0] ddat_ff [MMC_WAYS][MMC_SETS*MMC_LINE_BEATS];
  logic ilru_ff [MMC_SETS];
  logic dlru_ff [MMC_SETS];
  logic [31:0] x_pa;
  logic x_unc, x_aerr, x_berr;
  logic [2:0] x_pol;
  logic is_i;
  logic [MMC_IDX_W-1:0] idx;
  logic [MMC_BEAT_W-1:0] bt;
  logic [8:0] dix;
  logic hit0, hit1, hit;
  logic ivict, dvict;
  logic fill_we, st_we;
  logic [71:0] fill_word, sb_word;
  logic [8:0] sb_dix;

  function automatic logic [7:0] byte_par(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction : byte_par

  function automatic logic [7:0] word_par(input logic [63:0] d);
    return {6'h00, ^d[63:32], ^d[31:0]};
  endfunction : word_par

  function automatic logic [63:0] merge(input logic [63:0] o,
                                        input logic [63:0] n,
                                        input logic [7:0] be);
    logic [63:0] m;
    m = o;
    for (int i = 0; i < 8; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  mmc_xlate u_xlate (
    .vaddr(r_ff.va),
    .user_mode(~r_ff.kmode),
    .is_fetch(r_ff.kind == MMC_REQ_FETCH),
    .ibase(ibase),
    .ibound(ibound),
    .dbase(dbase),
    .dbound(dbound),
    .region_cache_policy(region_cache_policy),
    .paddr(x_pa),
    .uncached(x_unc),
    .policy(x_pol),
    .addr_err(x_aerr),
    .bound_err(x_berr)
  );

  mmc_way_sel u_isel (
    .lock_a(icache_lock_a),
    .lru_a(ilru_ff[idx]),
    .victim_b(ivict)
  );

  mmc_way_sel u_dsel (
    .lock_a(dcache_lock_a),
    .lru_a(dlru_ff[idx]),
    .victim_b(dvict)
  );

  always_comb begin
    is_i = (r_ff.kind == MMC_REQ_FETCH);
    idx = r_ff.va[MMC_TAG_LSB-1:MMC_IDX_LSB];
    bt = r_ff.va[MMC_IDX_LSB-1:MMC_BEAT_LSB];
    dix = {idx, bt};
    hit0 = is_i ? (itag_ff[0][idx][MMC_TAG_W+1] &&
                   itag_ff[0][idx][MMC_TAG_W-1:0] == x_pa[31:12])
                : (dtag_ff[0][idx][MMC_TAG_W+1] &&
                   dtag_ff[0][idx][MMC_TAG_W-1:0] == x_pa[31:12]);
    hit1 = is_i ? (itag_ff[1][idx][MMC_TAG_W+1] &&
                   itag_ff[1][idx][MMC_TAG_W-1:0] == x_pa[31:12])
                : (dtag_ff[1][idx][MMC_TAG_W+1] &&
                   dtag_ff[1][idx][MMC_TAG_W-1:0] == x_pa[31:12]);
    hit = hit0 | hit1;
    fill_we = (r_ff.st == MMC_ST_FILL) && mem_rvalid;
    fill_word = {is_i ? word_par(mem_rdata) : byte_par(mem_rdata),
                 mem_rdata};
    sb_dix = {r_ff.sb_idx, r_ff.sb_beat};
    sb_word = {byte_par(r_ff.sb_d), r_ff.sb_d};
    // Drained in any cycle that no load or fill uses the array
    st_we = r_ff.sb_v && !fill_we &&
            !(r_ff.st == MMC_ST_LOOK && r_ff.kind == MMC_REQ_LOAD);
    nxt_r = r_ff;
    nxt_r.rv = 1'b0;
    nxt_r.ev = 1'b0;
    nxt_r.perr = 1'b0;
    if (st_we) begin
      nxt_r.sb_v = 1'b0;
    end
    if (exc_return) begin
      nxt_r.kmode = 1'b0;
    end
    unique case (r_ff.st)
      MMC_ST_IDLE: begin
        if (intr_req) begin
          nxt_r.ev = 1'b1;
          nxt_r.ec = MMC_EXC_INTR;
          nxt_r.kmode = 1'b1;
          nxt_r.evec = intr_vec_en ? MMC_VEC_INTR : MMC_VEC_GENERAL;
        end else if (req_valid) begin
          nxt_r.st = MMC_ST_LOOK;
          nxt_r.kind = req_kind;
          nxt_r.va = req_vaddr;
          nxt_r.wd = req_wdata;
          nxt_r.be = req_be;
        end
      end
      MMC_ST_LOOK: begin
        nxt_r.pa = x_pa;
        nxt_r.pol = x_pol;
        nxt_r.unc = x_unc;
        nxt_r.st = MMC_ST_IDLE;
        nxt_r.early = 1'b0;
        if (x_aerr || x_berr) begin
          nxt_r.ev = 1'b1;
          nxt_r.ec = x_aerr ? MMC_EXC_ADDR : MMC_EXC_BOUND;
          nxt_r.bva = r_ff.va;
          nxt_r.kmode = 1'b1;
          nxt_r.evec = MMC_VEC_GENERAL;
        end else if (watch_en && r_ff.va[31:3] ==
                     (is_i ? iwatch[31:3] : dwatch[31:3])) begin
          nxt_r.ev = 1'b1;
          nxt_r.ec = MMC_EXC_WATCH;
          nxt_r.bva = r_ff.va;
          nxt_r.kmode = 1'b1;
          nxt_r.evec = MMC_VEC_GENERAL;
        end else if (r_ff.kind == MMC_REQ_STORE && r_ff.sb_v) begin
          nxt_r.st = MMC_ST_LOOK;
        end else if (x_unc) begin
          nxt_r.st = MMC_ST_UNC;
          nxt_r.mreq = 1'b1;
          nxt_r.mwe = (r_ff.kind == MMC_REQ_STORE);
          nxt_r.mblk = 1'b0;
          nxt_r.maddr = x_pa;
          nxt_r.mwd = r_ff.wd;
          nxt_r.mbe = r_ff.be;
        end else if (hit) begin
          if (r_ff.kind == MMC_REQ_STORE) begin
            nxt_r.sb_v = 1'b1;
            nxt_r.sb_way = hit1;
            nxt_r.sb_idx = idx;
            nxt_r.sb_beat = bt;
            nxt_r.sb_d = merge(ddat_ff[hit1][dix][63:0], r_ff.wd, r_ff.be);
            nxt_r.sb_be = r_ff.be;
            nxt_r.sb_dirty = (x_pol != MMC_POL_WTA);
            if (x_pol == MMC_POL_WTA || x_pol == MMC_POL_WTN) begin
              nxt_r.st = MMC_ST_WMEM;
              nxt_r.mreq = 1'b1;
              nxt_r.mwe = 1'b1;
              nxt_r.mblk = 1'b0;
              nxt_r.maddr = x_pa;
              nxt_r.mwd = r_ff.wd;
              nxt_r.mbe = r_ff.be;
            end
          end else begin
            nxt_r.rv = 1'b1;
            nxt_r.rd = is_i ? idat_ff[hit1][dix][63:0]
                            : ddat_ff[hit1][dix][63:0];
            nxt_r.perr = is_i
              ? (word_par(idat_ff[hit1][dix][63:0]) !=
                 idat_ff[hit1][dix][71:64])
              : (byte_par(ddat_ff[hit1][dix][63:0]) !=
                 ddat_ff[hit1][dix][71:64]);
          end
        end else if (r_ff.kind == MMC_REQ_STORE && x_pol == MMC_POL_WTN) begin
          nxt_r.st = MMC_ST_WMEM;
          nxt_r.mreq = 1'b1;
          nxt_r.mwe = 1'b1;
          nxt_r.mblk = 1'b0;
          nxt_r.maddr = x_pa;
          nxt_r.mwd = r_ff.wd;
          nxt_r.mbe = r_ff.be;
        end else begin
          nxt_r.st = MMC_ST_FILL;
          nxt_r.way = is_i ? ivict : dvict;
          nxt_r.beat = bt;
          nxt_r.mreq = 1'b1;
          nxt_r.mwe = 1'b0;
          nxt_r.mblk = 1'b1;
          nxt_r.maddr = x_pa;
        end
      end
      MMC_ST_FILL: begin
        if (mem_ready) begin
          nxt_r.mreq = 1'b0;
        end
        if (mem_rvalid) begin
          // Beats arrive in critical-first order from the missed word
          nxt_r.beat = r_ff.beat + 2'd1;
          if (!is_i && !r_ff.early && r_ff.kind == MMC_REQ_LOAD) begin
            nxt_r.early = 1'b1;
            nxt_r.rv = 1'b1;
            nxt_r.rd = mem_rdata;
          end
          if (r_ff.beat + 2'd1 == bt) begin
            // Store miss retried in lookup after the fill completes
            nxt_r.st = (r_ff.kind == MMC_REQ_STORE) ? MMC_ST_LOOK
                                                    : MMC_ST_IDLE;
            if (is_i) begin
              nxt_r.rv = 1'b1;
              nxt_r.rd = idat_ff[r_ff.way][dix][63:0];
            end
          end
        end
      end
      MMC_ST_UNC, MMC_ST_WMEM: begin
        if (mem_ready) begin
          nxt_r.mreq = 1'b0;
          nxt_r.st = MMC_ST_IDLE;
          if (r_ff.st == MMC_ST_UNC && r_ff.kind != MMC_REQ_STORE) begin
            nxt_r.st = MMC_ST_FILL;
            nxt_r.early = 1'b1;
          end
        end
      end
      default: begin
        nxt_r.st = MMC_ST_IDLE;
      end
    endcase
    // Uncached read answer rides the same rvalid path, no array write
    if (r_ff.st == MMC_ST_FILL && r_ff.unc && mem_rvalid) begin
      nxt_r.rv = 1'b1;
      nxt_r.rd = mem_rdata;
      nxt_r.st = MMC_ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_ff <= '0;
      r_ff.kmode <= 1'b1;
      r_ff.st <= MMC_ST_IDLE;
      for (int s = 0; s < MMC_SETS; s++) begin
        for (int w = 0; w < MMC_WAYS; w++) begin
          itag_ff[w][s] <= '0;
          dtag_ff[w][s] <= '0;
        end
        ilru_ff[s] <= 1'b0;
        dlru_ff[s] <= 1'b0;
      end
    end else begin
      r_ff <= nxt_r;
      if (fill_we && !r_ff.unc) begin
        if (is_i) begin
          idat_ff[r_ff.way][{idx, r_ff.beat}] <= fill_word;
          itag_ff[r_ff.way][idx] <= {^{1'b1, x_pa[31:12]}, 1'b1, 1'b0,
                                     x_pa[31:12]};
          // Refilled set becomes most recent, the other one the victim
          ilru_ff[idx] <= r_ff.way;
        end else begin
          ddat_ff[r_ff.way][{idx, r_ff.beat}] <= fill_word;
          dtag_ff[r_ff.way][idx] <= {^{1'b1, x_pa[31:12]}, 1'b1, 1'b0,
                                     x_pa[31:12]};
          dlru_ff[idx] <= r_ff.way;
        end
      end
      if (st_we) begin
        ddat_ff[r_ff.sb_way][sb_dix] <= sb_word;
        if (r_ff.sb_dirty) begin
          dtag_ff[r_ff.sb_way][r_ff.sb_idx][MMC_TAG_W] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    mem_req = r_ff.mreq;
    mem_we = r_ff.mwe;
    mem_block = r_ff.mblk;
    mem_addr = r_ff.maddr;
    mem_wdata = r_ff.mwd;
    mem_be = r_ff.mbe;
    resp_valid = r_ff.rv;
    resp_rdata = r_ff.rd;
    busy = (r_ff.st != MMC_ST_IDLE);
    exc_valid = r_ff.ev;
    exc_code = r_ff.ec;
    exc_vector = r_ff.evec;
    bad_vaddr = r_ff.bva;
    kernel_mode = r_ff.kmode;
    parity_err = r_ff.perr;
  end
endmodule : mmc_top

//--- test/mmc_chk.sv
`timescale 1ns/1ps
module mmc_chk
  import mmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire mmc_req_e req_kind,
  input wire logic [31:0] req_vaddr,
  input wire logic intr_req,
  input wire logic [31:0] ibase,
  input wire logic [31:0] ibound,
  input wire logic [31:0] dbase,
  input wire logic [31:0] dbound,
  input wire logic watch_en,
  input wire logic intr_vec_en,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire logic mem_req,
  input wire logic mem_block,
  input wire logic [31:0] mem_addr,
  input wire logic resp_valid,
  input wire logic busy,
  input wire logic exc_valid,
  input wire mmc_exc_e exc_code,
  input wire logic [31:0] exc_vector,
  input wire logic [31:0] bad_vaddr,
  input wire logic kernel_mode
);
  logic tk;
  logic usr_ff;
  logic blk_ff;
  logic [2:0] bt_ff;
  logic [31:0] va_ff;
  mmc_req_e kd_ff;
  logic [31:0] kpa;
  logic [31:0] upa;
  assign tk = req_valid && !busy && !intr_req;
  assign kpa = va_ff & MMC_KPHYS_MASK;
  assign upa = va_ff + ((kd_ff == MMC_REQ_FETCH) ? ibase : dbase);
  // Beats are counted per request so restart timing can be judged
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      va_ff <= '0;
      usr_ff <= 1'h0;
      blk_ff <= 1'h0;
      bt_ff <= 3'h0;
      kd_ff <= MMC_REQ_FETCH;
    end else if (tk) begin
      va_ff <= req_vaddr;
      usr_ff <= !kernel_mode;
      kd_ff <= req_kind;
      blk_ff <= 1'h0;
      bt_ff <= 3'h0;
    end else begin
      if (mem_req && mem_block) blk_ff <= 1'h1;
      if (mem_rvalid) bt_ff <= bt_ff + 3'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_user_tk;
    tk && !kernel_mode;
  endsequence
  a_kseg_user: assert property (
    s_user_tk ##0 req_vaddr >= MMC_KSEG_START
    |-> ##[1:3] exc_valid && exc_code == MMC_EXC_ADDR && bad_vaddr == va_ff)
    else $error("user kernel access not faulted");
  a_bound_err: assert property (
    s_user_tk ##0 !watch_en ##0
    req_vaddr < MMC_KSEG_START ##0 req_vaddr >
    ((req_kind == MMC_REQ_FETCH) ? ibound : dbound)
    |-> ##[1:3] exc_valid && exc_code == MMC_EXC_BOUND)
    else $error("out of bound access not faulted");
  a_user_base: assert property (
    mem_req && usr_ff
    |-> mem_addr[31:5] == upa[31:5])
    else $error("user address not relocated");
  a_cached_win: assert property (
    mem_req && !usr_ff &&
    va_ff[31:29] == MMC_TOP_CACHED |-> mem_addr[31:5] == kpa[31:5])
    else $error("cached window mapping wrong");
  a_uncached_win: assert property (
    mem_req && !usr_ff &&
    va_ff[31:29] == MMC_TOP_UNCACHED
    |-> !mem_block && mem_addr[31:3] == kpa[31:3])
    else $error("uncached window mapping wrong");
  a_top_space: assert property (
    mem_req && !usr_ff && va_ff[31:30] == 2'h3
    |-> mem_addr[31:5] == va_ff[31:5])
    else $error("top space not identity");
  a_exc_kernel: assert property (
    exc_valid |-> ##[0:1] kernel_mode)
    else $error("exception left user mode");
  // Vector follows the enable seen when the interrupt was taken
  a_intr_vec: assert property (
    exc_valid && exc_code == MMC_EXC_INTR
    |-> exc_vector == ($past(intr_vec_en) ? MMC_VEC_INTR : MMC_VEC_GENERAL))
    else $error("interrupt vector wrong");
  a_gen_vec: assert property (
    exc_valid && exc_code != MMC_EXC_INTR
    |-> exc_vector == MMC_VEC_GENERAL)
    else $error("general vector wrong");
  a_fetch_line: assert property (
    resp_valid && blk_ff &&
    kd_ff == MMC_REQ_FETCH |-> bt_ff == 3'h4)
    else $error("fetch resumed before line end");
  a_load_first: assert property (
    resp_valid && blk_ff &&
    kd_ff == MMC_REQ_LOAD |-> bt_ff == 3'h1)
    else $error("load not resumed on first beat");
  a_req_stands: assert property (mem_req && !mem_ready
    |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped early");
endmodule : mmc_chk
bind mmc_top mmc_chk mmc_chk_inst (.ref_clk, .resetn, .req_valid, .req_kind,
  .req_vaddr, .intr_req, .ibase, .ibound, .dbase, .dbound, .watch_en,
  .intr_vec_en, .mem_ready, .mem_rvalid, .mem_req, .mem_block, .mem_addr,
  .resp_valid, .busy, .exc_valid, .exc_code, .exc_vector, .bad_vaddr,
  .kernel_mode);

//--- test/mmc_mem_model.sv
`timescale 1ns/1ps
module mmc_mem_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_block,
  input wire logic [31:0] mem_addr,
  output logic mem_ready,
  output logic mem_rvalid,
  output logic [63:0] mem_rdata
);
  logic [2:0] left_ff;
  logic [31:0] cur_ff;
  logic slow_ff;
  // Beat data encodes its address; idle cycles invert the last value every cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_ready <= 1'h0;
      mem_rvalid <= 1'h0;
      mem_rdata <= '0;
      left_ff <= 3'h0;
      cur_ff <= '0;
      slow_ff <= 1'h0;
    end else begin
      slow_ff <= !slow_ff;
      mem_ready <= mem_req && !mem_ready && slow_ff;
      mem_rvalid <= 1'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_ready && !mem_we) begin
        left_ff <= mem_block ? 3'h4 : 3'h1;
        cur_ff <= {mem_addr[31:3], 3'h0};
      end else if (left_ff != 3'h0) begin
        mem_rvalid <= 1'h1;
        mem_rdata <= {~cur_ff, cur_ff};
        cur_ff[4:3] <= cur_ff[4:3] + 2'h1;
        left_ff <= left_ff - 3'h1;
      end
    end
  end
endmodule : mmc_mem_model

//--- test/mmc_top_tb_top.sv
`timescale 1ns/1ps
module mmc_top_tb_top;
  import mmc_pkg::*;
  logic ref_clk, resetn, req_valid, intr_req, exc_return, watch_en;
  logic intr_vec_en, icache_lock_a, dcache_lock_a, mem_ready, mem_rvalid;
  logic mem_req, mem_we, mem_block, resp_valid, busy, exc_valid;
  logic kernel_mode, parity_err, sm, sw, sb, gr, ge, pe;
  mmc_req_e req_kind;
  mmc_exc_e exc_code, ec;
  logic [31:0] req_vaddr, ibase, ibound, dbase, dbound, iwatch, dwatch;
  logic [31:0] mem_addr, exc_vector, bad_vaddr, ma, ev;
  logic [63:0] req_wdata, mem_rdata, mem_wdata, resp_rdata, rd, mw;
  logic [7:0] req_be, mem_be, mbe;
  logic [23:0] region_cache_policy;
  int mismatches, checks_done;
  mmc_top mmc_top_inst (.*);
  mmc_mem_model mmc_mem_model_inst (.ref_clk, .resetn, .mem_req, .mem_we,
    .mem_block, .mem_addr, .mem_ready, .mem_rvalid, .mem_rdata);
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  task stop_test;
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [63:0] ed(input logic [31:0] a);
    return {~{a[31:3], 3'h0}, a[31:3], 3'h0};
  endfunction : ed
  // Watches one request to completion, keeping its first bus cycle
  task run;
    sm = 0;
    gr = 0;
    ge = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge ref_clk);
      #1;
      if (mem_req === 1'h1 && !sm) begin
        sm = 1;
        ma = mem_addr;
        sb = mem_block;
        sw = mem_we;
        mw = mem_wdata;
        mbe = mem_be;
      end
      if (resp_valid === 1'h1) begin
        rd = resp_rdata;
        pe = parity_err;
      end
      if (exc_valid === 1'h1) begin
        ge = 1;
        ec = exc_code;
        ev = exc_vector;
      end
      if (i > 1 && busy === 1'h0) break;
    end
  endtask : run
  task req(input mmc_req_e k, input logic [31:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    #1;
    req_valid = 1;
    req_kind = k;
    req_vaddr = a;
    req_wdata = d;
    @(posedge ref_clk);
    #1;
    req_valid = 0;
    run();
  endtask : req
  task aba(input mmc_req_e k, input logic [31:0] a, input logic [31:0] b);
    req(k, a, '0);
    req(k, b, '0);
    req(k, a, '0);
  endtask : aba
  task leave_kernel;
    @(posedge ref_clk);
    #1;
    exc_return = 1;
    @(posedge ref_clk);
    #1;
    exc_return = 0;
  endtask : leave_kernel
  task t_windows;
    req(MMC_REQ_LOAD, 32'hA000_0108, '0);
    chk("unc_addr", 32'h0000_0108, {ma[31:3], 3'h0});
    chk("unc_block", 1'h0, sb);
    chk("unc_data", ed(32'h0000_0108), rd);
    req(MMC_REQ_STORE, 32'hC000_0308, 64'h0A0B_0C0D_0E0F_1011);
    chk("wtn_we", 1'h1, sw);
    chk("wtn_addr", 32'hC000_0308, {ma[31:3], 3'h0});
    req(MMC_REQ_LOAD, 32'hC000_0308, '0);
    chk("wtn_alloc", 1'h1, sm);
    req(MMC_REQ_STORE, 32'hC000_0308, 64'h5566_7788_99AA_BBCC);
    chk("wtn_hit_we", 1'h1, sw);
  endtask : t_windows
  task t_policy;
    req(MMC_REQ_LOAD, 32'h8000_0048, '0);
    chk("fill_block", 1'h1, sb);
    chk("fill_data", ed(32'h0000_0048), rd);
    req(MMC_REQ_LOAD, 32'h8000_0048, '0);
    chk("hit_mem", 1'h0, sm);
    chk("hit_parity", 1'h0, pe);
    req(MMC_REQ_STORE, 32'h8000_0048, 64'h1234_5678_9ABC_DEF0);
    chk("wb_mem", 1'h0, sm);
    req(MMC_REQ_LOAD, 32'h8000_0048, '0);
    chk("wb_data", 64'h1234_5678_9ABC_DEF0, rd);
    region_cache_policy[14:12] = MMC_POL_WTA;
    req(MMC_REQ_STORE, 32'h8000_0048, 64'h0F0F_1E1E_2D2D_3C3C);
    chk("wt_we", 1'h1, sw);
    chk("wt_wdata", 64'h0F0F_1E1E_2D2D_3C3C, mw);
    chk("wt_be", 8'hFF, mbe);
    req(MMC_REQ_LOAD, 32'h8000_0048, '0);
    chk("wt_data", 64'h0F0F_1E1E_2D2D_3C3C, rd);
  endtask : t_policy
  task t_lock;
    dcache_lock_a = 1;
    aba(MMC_REQ_LOAD, 32'h8000_0400, 32'h8000_1400);
    chk("dlock_refill", 1'h1, sm);
    dcache_lock_a = 0;
    aba(MMC_REQ_LOAD, 32'h8000_0800, 32'h8000_1800);
    chk("two_way_hit", 1'h0, sm);
    icache_lock_a = 1;
    aba(MMC_REQ_FETCH, 32'h8000_2010, 32'h8000_3010);
    chk("ilock_refill", 1'h1, sm);
    chk("fetch_data", ed(32'h0000_2010), rd);
  endtask : t_lock
  task t_user;
    leave_kernel();
    chk("user_mode", 1'h0, kernel_mode);
    req(MMC_REQ_LOAD, 32'h0000_0108, '0);
    chk("user_daddr", 32'h0010_0108, {ma[31:3], 3'h0});
    req(MMC_REQ_FETCH, 32'h0000_0020, '0);
    chk("user_iaddr", 32'h0020_0020, {ma[31:3], 3'h0});
    req(MMC_REQ_LOAD, 32'h0000_1008, '0);
    chk("bound_exc", MMC_EXC_BOUND, ec);
    chk("exc_kernel", 1'h1, kernel_mode);
    leave_kernel();
    req(MMC_REQ_STORE, 32'h8000_0010, '0);
    chk("kseg_exc", MMC_EXC_ADDR, ec);
    chk("bad_vaddr", 32'h8000_0010, bad_vaddr);
    watch_en = 1;
    req(MMC_REQ_LOAD, 32'h8000_0048, '0);
    chk("watch_exc", MMC_EXC_WATCH, ec);
    watch_en = 0;
  endtask : t_user
  task t_intr;
    for (int v = 0; v < 2; v++) begin
      intr_vec_en = (v == 0);
      @(posedge ref_clk);
      #1;
      intr_req = 1;
      run();
      intr_req = 0;
      chk("intr_code", MMC_EXC_INTR, ec);
      chk("intr_vec", v ? MMC_VEC_GENERAL : MMC_VEC_INTR, ev);
    end
  endtask : t_intr
  initial begin
    // Region 0 uncached keeps user addresses exact; region 6 no-allocate
    {resetn, req_valid, intr_req, exc_return, watch_en} = '0;
    {intr_vec_en, icache_lock_a, dcache_lock_a} = '0;
    req_kind = MMC_REQ_FETCH;
    {req_vaddr, req_wdata, iwatch} = '0;
    req_be = 8'hFF;
    dwatch = 32'h8000_0048;
    ibase = 32'h0020_0000;
    ibound = 32'h0000_00FF;
    dbase = 32'h0010_0000;
    dbound = 32'h0000_0FFF;
    region_cache_policy = 24'h0C_0001;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("rst_kernel", 1'h1, kernel_mode);
    chk("rst_busy", 1'h0, busy);
    resetn = 1;
    t_windows();
    t_policy();
    t_lock();
    t_user();
    t_intr();
    stop_test();
  end
  initial begin
    #(100 * 20000);
    mismatches++;
    stop_test();
  end
endmodule : mmc_top_tb_top
